// *** bench/osc_source.sv ***
`timescale 1ns/100ps
module osc_source (
	input  wire logic clk_sys,   // Bench clock
	input  wire logic lock_req,  // Let the PLL lock
	input  wire logic stable_req, // Crystal start-up done
	output logic      osc_clk,   // Primary source
	output logic      pll_clk,   // PLL output
	output logic      pll_lock,  // Lock flag
	output logic      rc_clk,    // Slow RC source
	output logic      osc_stable // Start-up done
);
	logic [3:0] cnt_ff = 4'h0;

	always_ff @(posedge clk_sys) begin
		cnt_ff <= cnt_ff + 4'h1;
	end

	// ==========================================
	// Sources are sampled by clk_sys, so kept slow
	assign osc_clk    = cnt_ff[1];
	assign pll_clk    = cnt_ff[0];
	assign rc_clk     = cnt_ff[3];
	assign pll_lock   = lock_req;
	assign osc_stable = stable_req;
endmodule : osc_source

// *** bench/tb_top.sv ***
`timescale 1ns/100ps
module tb_top;
	import osc_tree_pkg::*;
	logic        clk_sys = 1'b0;
	logic        rst = 1'b1;
	logic        lock_req = 1'b0;
	logic        stable_req = 1'b1;
	logic        ce = 1'b1;
	logic        osc_clk, pll_clk, pll_lock, rc_clk, osc_stable;
	logic        prog_load = 1'b0;
	logic [11:0] prog_cfg = 12'h000;
	logic [3:0]  feat = 4'h0;
	logic        pa_o = 1'b0;
	logic        pa_oe = 1'b0;
	logic        pin_o, pin_oe;
	clk_out_s    clks;
	logic [3:0]  avs_address = 4'h0;
	logic        avs_read = 1'b0;
	logic        avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0;
	logic [31:0] avs_readdata, q;
	logic        avs_waitrequest;
	int          n_mismatch = 0;
	int          n_checks = 0;
	int          nc, nu;
	int          div6[4] = '{2, 3, 4, 6};

	always #20 clk_sys = ~clk_sys;

	osc_source i_src (.clk_sys(clk_sys), .lock_req(lock_req), .stable_req(stable_req),
		.osc_clk(osc_clk),
		.pll_clk(pll_clk), .pll_lock(pll_lock), .rc_clk(rc_clk), .osc_stable(osc_stable));

	osc_tree i_dut (.clk_sys(clk_sys), .rst(rst), .ce(ce), .osc_clk(osc_clk),
		.pll_clk(pll_clk), .pll_lock(pll_lock), .rc_clk(rc_clk), .osc_stable(osc_stable),
		.prog_load(prog_load), .prog_cfg(prog_cfg), .por_timer_en(feat[0]),
		.fscm_en(feat[1]), .wdt_en(feat[2]), .two_speed_en(feat[3]),
		.port_a_bit6_o(pa_o), .port_a_bit6_oe(pa_oe), .clock_out_pin_o(pin_o),
		.clock_out_pin_oe(pin_oe), .clks(clks), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));

	task automatic final_report();
		$display("checks %0d mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask : final_report

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[FAIL] %0t value %h expected %h", $time, got, exp);
		end
	endtask : chk

	task automatic near(input int got, input int exp);
		n_checks++;
		if (got < exp - 1 || got > exp + 1) begin
			n_mismatch++;
			$display("[FAIL] %0t edges %0d expected %0d", $time, got, exp);
		end
	endtask : near

	// Called just after an edge; holds until waitrequest is seen low
	task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
		int i;
		avs_address   <= a;
		avs_write     <= wr;
		avs_read      <= !wr;
		avs_writedata <= d;
		for (i = 0; i < 20; i++) begin
			@(posedge clk_sys);
			if (avs_waitrequest === 1'b0) break;
		end
		q = avs_readdata;
		avs_read  <= 1'b0;
		avs_write <= 1'b0;
		if (i == 20) begin
			n_mismatch++;
			final_report();
		end
		@(posedge clk_sys);
	endtask : bus

	task automatic load(input logic [11:0] cfg);
		prog_cfg  <= cfg;
		prog_load <= 1'b1;
		@(posedge clk_sys);
		prog_load <= 1'b0;
		repeat (2) @(posedge clk_sys);
	endtask : load

	// Rising edges of the derived clocks over 240 cycles
	task automatic count();
		logic pc, pu;
		nc = 0;
		nu = 0;
		pc = clks.core_clk;
		pu = clks.usb_clk;
		repeat (240) begin
			@(posedge clk_sys);
			#1;
			if (clks.core_clk && !pc) nc++;
			if (clks.usb_clk && !pu) nu++;
			pc = clks.core_clk;
			pu = clks.usb_clk;
		end
		@(posedge clk_sys);
	endtask : count

	initial begin
		repeat (3) @(posedge clk_sys);
		rst <= 1'b0;
		@(posedge clk_sys);
		bus(1'b0, ADDR_CFG, 32'h0);
		chk(q, 32'h0);
		bus(1'b0, 4'hC, 32'h0);
		chk(q, 32'h0);
		bus(1'b1, ADDR_CFG, 32'h5);
		bus(1'b0, ADDR_CFG, 32'h0);
		chk(q, 32'h0);
		bus(1'b1, ADDR_CTRL, 32'h3);
		bus(1'b0, ADDR_CTRL, 32'h0);
		chk(q, 32'h3);
		bus(1'b1, ADDR_CTRL, 32'h0);
		for (int m = 0; m < NUM_MODES; m++) begin
			pa_o  <= m[0];
			pa_oe <= m[1];
			load(12'(m));
			bus(1'b0, ADDR_CFG, 32'h0);
			chk(q[11:0], 12'(m));
			chk(32'(clks.pll_en), 32'(m == 1 || m == 3 || m == 6 || m == 7));
			if (m == 4 || m == 6 || m == 11) chk(32'(pin_oe), 32'h1);
			if (m == 5 || m == 7 || m == 10) begin
				chk({pin_o, pin_oe}, {m[0], m[1]});
				bus(1'b0, ADDR_STATUS, 32'h0);
				chk(32'(q[1]), 32'h1);
			end
		end
		load(12'h000);
		chk(32'(clks.rc_en), 32'h0);
		for (int f = 0; f < 4; f++) begin
			feat <= 4'(1 << f);
			repeat (2) @(posedge clk_sys);
			chk(32'(clks.rc_en), 32'h1);
		end
		feat <= 4'h0;
		for (int d = 0; d < 4; d++) begin
			load(12'(d * 16));
			count();
			near(nc, 60 / (d + 1));
		end
		bus(1'b1, ADDR_CTRL, 32'h1);
		load(12'h003);
		count();
		chk(nc + nu, 0);
		lock_req <= 1'b1;
		for (int d = 0; d < 4; d++) begin
			load(12'(3 + d * 16));
			count();
			near(nc, 120 / div6[d]);
			near(nu, 60);
		end
		load(12'h803);
		count();
		near(nu, 15);
		load(12'h101);
		bus(1'b0, ADDR_STATUS, 32'h0);
		chk(32'(clks.pll_en), 32'h1);
		chk(32'({q[7:4], q[2]}), 32'h04);
		load(12'h001);
		bus(1'b0, ADDR_STATUS, 32'h0);
		chk(32'({q[7:4], q[2]}), 32'h03);
		load(12'h703);
		bus(1'b0, ADDR_STATUS, 32'h0);
		chk(32'({q[7:4], q[2]}), 32'h19);
		stable_req <= 1'b0;
		load(12'h000);
		count();
		chk(nc, 0);
		load(12'h004);
		count();
		near(nc, 60);
		stable_req <= 1'b1;
		bus(1'b1, ADDR_CTRL, 32'h3);
		load(12'h808);
		chk(32'(clks.rc_en), 32'h1);
		count();
		near(nc, 15);
		near(nu, 15);
		ce <= 1'b0;
		load(12'h00A);
		ce <= 1'b1;
		bus(1'b0, ADDR_CFG, 32'h0);
		chk(q, 32'h808);
		rst <= 1'b1;
		repeat (3) @(posedge clk_sys);
		chk({clks.core_clk, clks.usb_clk}, 2'h0);
		rst <= 1'b0;
		@(posedge clk_sys);
		bus(1'b0, ADDR_CTRL, 32'h0);
		chk(q, 32'h0);
		final_report();
	end
endmodule : tb_top

// *** core/osc_tree.sv ***
// The Avalon-MM register port and the placing of the registers were chosen for this implementation.
`timescale 1ns/100ps
module osc_tree
	import osc_tree_pkg::*;
(
	input  wire logic                  clk_sys,        // Bus clock
	input  wire logic                  rst,            // Sync reset, high
	input  wire logic                  ce,             // Clock enable
	input  wire logic                  osc_clk,        // Primary osc, sampled
	input  wire logic                  pll_clk,        // 96 MHz PLL, sampled
	input  wire logic                  pll_lock,       // PLL locked
	input  wire logic                  rc_clk,         // 31 kHz RC, sampled
	input  wire logic                  osc_stable,     // Crystal start-up done
	input  wire logic                  prog_load,      // Reprogram strobe
	input  wire logic [11:0]           prog_cfg,       // Nonvolatile image
	input  wire logic                  por_timer_en,   // Power-up timer on
	input  wire logic                  fscm_en,        // Clock monitor on
	input  wire logic                  wdt_en,         // Watchdog on
	input  wire logic                  two_speed_en,   // Two-speed start on
	input  wire logic                  port_a_bit6_o,  // Port latch bit6
	input  wire logic                  port_a_bit6_oe, // Port tris bit6
	output logic                       clock_out_pin_o,  // Pin drive
	output logic                       clock_out_pin_oe, // Pin enable
	output osc_tree_pkg::clk_out_s     clks,           // Derived clocks
	input  wire logic [3:0]            avs_address,    // Byte address
	input  wire logic                  avs_read,       // Read
	input  wire logic                  avs_write,      // Write
	input  wire logic [31:0]           avs_writedata,  // Write data
	output logic [31:0]                avs_readdata,   // Read data
	output logic                       avs_waitrequest // Wait
);
	import osc_tree_pkg::*;

	// ==========================================
	// Configuration and control state
	logic [11:0] cfg_ff, nxt_cfg;
	logic [3:0]  ctrl_ff, nxt_ctrl;
	logic        ack_ff, nxt_ack;
	logic [31:0] rd_ff, nxt_rd;
	osc_mode_e   mode;
	logic [1:0]  cpu_sel;
	logic [2:0]  pre_sel;
	logic        usb_ls, usb_en, core_sel_rc;

	assign mode        = osc_mode_e'(cfg_ff[CFG_MODE_LSB +: 4]);
	assign cpu_sel     = cfg_ff[CFG_CPU_LSB +: 2];
	assign pre_sel     = cfg_ff[CFG_PRE_LSB +: 3];
	assign usb_ls      = cfg_ff[CFG_USBLS_BIT];
	assign usb_en      = ctrl_ff[0];
	assign core_sel_rc = ctrl_ff[1];

	// ==========================================
	// Mode decode
	logic pll_mode, ext_mode, gpio_mode, rc_mode, quarter_out;
	always_comb begin
		pll_mode    = 1'b0;
		ext_mode    = 1'b0;
		gpio_mode   = 1'b0;
		rc_mode     = 1'b0;
		quarter_out = 1'b0;
		case (mode)
			CRYSTAL_PLL_MODE, FAST_CRYSTAL_PLL_MODE: pll_mode = 1'b1;
			EXTERNAL_CLOCK_MODE, RC_CORE_EXTCLK_QUARTER_OUT_MODE: begin
				ext_mode    = 1'b1;
				quarter_out = 1'b1;
				rc_mode     = (mode == RC_CORE_EXTCLK_QUARTER_OUT_MODE);
			end
			EXTERNAL_CLOCK_GPIO_MODE, RC_CORE_EXTCLK_GPIO_MODE: begin
				ext_mode  = 1'b1;
				gpio_mode = 1'b1;
				rc_mode   = (mode == RC_CORE_EXTCLK_GPIO_MODE);
			end
			EXTERNAL_CLOCK_PLL_MODE: begin
				ext_mode    = 1'b1;
				pll_mode    = 1'b1;
				quarter_out = 1'b1;
			end
			EXTERNAL_CLOCK_PLL_GPIO_MODE: begin
				ext_mode  = 1'b1;
				pll_mode  = 1'b1;
				gpio_mode = 1'b1;
			end
			RC_CORE_FAST_CRYSTAL_USB_MODE, RC_CORE_CRYSTAL_USB_MODE: rc_mode = 1'b1;
			default: ;
		endcase
	end

	// ==========================================
	// Edge detection of sampled source clocks
	logic osc_q_ff, pll_q_ff, rc_q_ff;
	logic osc_rise, pll_rise, rc_rise;
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			osc_q_ff <= 1'b0;
			pll_q_ff <= 1'b0;
			rc_q_ff  <= 1'b0;
		end else if (ce) begin
			osc_q_ff <= osc_clk;
			pll_q_ff <= pll_clk;
			rc_q_ff  <= rc_clk;
		end
	end
	assign osc_rise = osc_clk & ~osc_q_ff;
	assign pll_rise = pll_clk & ~pll_q_ff;
	assign rc_rise  = rc_clk & ~rc_q_ff;

	// Crystal modes wait for start-up; external clocks need none
	logic osc_ok, pll_ok;
	assign osc_ok = ext_mode | osc_stable;
	// In crystal-PLL mode PLL output used only with fixed 4 MHz in; prescale ratio 1 then
	assign pll_ok = pll_mode & pll_lock & osc_ok &
		((mode != CRYSTAL_PLL_MODE) | (pre_sel == 3'h0));

	// ==========================================
	// Dividers: one counter and toggle each
	localparam int NDIV = 4;
	logic [NDIV-1:0] div_tick, div_out, div_run, div_src;
	logic [3:0]      div_ratio [NDIV];
	logic [3:0]      pre_ratio;
	logic [3:0]      cnt_ff [NDIV];
	logic [3:0]      nxt_cnt [NDIV];
	logic [NDIV-1:0] tog_ff, nxt_tog;

	always_comb begin
		case (pre_sel)
			3'h0: pre_ratio = 4'h1;
			3'h1: pre_ratio = 4'h2;
			3'h2: pre_ratio = 4'h3;
			3'h3: pre_ratio = 4'h4;
			3'h4: pre_ratio = 4'h5;
			3'h5: pre_ratio = 4'h6;
			3'h6: pre_ratio = 4'hA;
			default: pre_ratio = 4'hC;
		endcase
	end

	// 0: core postscale, 1: USB full speed, 2: USB low speed, 3: quarter out
	always_comb begin
		div_ratio[0] = 4'h1;
		if (pll_mode) begin
			case (cpu_sel)
				2'h0: div_ratio[0] = 4'h2;
				2'h1: div_ratio[0] = 4'h3;
				2'h2: div_ratio[0] = 4'h4;
				default: div_ratio[0] = 4'h6;
			endcase
		end else begin
			div_ratio[0] = 4'(cpu_sel) + 4'h1;
		end
		div_ratio[1] = USB_FS_DIV;
		div_ratio[2] = LS_DIV;
		div_ratio[3] = CLKOUT_DIV;
	end

	assign div_tick[0] = pll_mode ? pll_rise : osc_rise;
	assign div_tick[1] = pll_rise;
	assign div_tick[2] = osc_rise;
	assign div_tick[3] = osc_rise;
	// Source levels, needed when a divider passes its source through
	assign div_src[0]  = pll_mode ? pll_clk : osc_clk;
	assign div_src[1]  = pll_clk;
	assign div_src[2]  = osc_clk;
	assign div_src[3]  = osc_clk;
	assign div_run[0]  = pll_mode ? pll_ok : osc_ok;
	assign div_run[1]  = pll_ok;
	assign div_run[2]  = osc_ok;
	assign div_run[3]  = osc_ok;

	genvar gi;
	generate
		for (gi = 0; gi < NDIV; gi++) begin : g_div
			// Output registered; duty may be uneven for odd ratios
			always_comb begin
				nxt_cnt[gi] = cnt_ff[gi];
				nxt_tog[gi] = tog_ff[gi];
				if (!div_run[gi]) begin
					nxt_cnt[gi] = 4'h0;
					nxt_tog[gi] = 1'b0;
				end else if (div_ratio[gi] == 4'h1) begin
					// Ratio one: a rising-edge counter would stick high, so follow the source
					nxt_cnt[gi] = 4'h0;
					nxt_tog[gi] = div_src[gi];
				end else if (div_tick[gi]) begin
					if (cnt_ff[gi] + 4'h1 >= div_ratio[gi]) begin
						nxt_cnt[gi] = 4'h0;
						nxt_tog[gi] = 1'b1;
					end else begin
						nxt_cnt[gi] = cnt_ff[gi] + 4'h1;
						nxt_tog[gi] = (cnt_ff[gi] + 4'h1) < (div_ratio[gi] >> 1);
					end
				end
			end
			always_ff @(posedge clk_sys) begin
				if (rst) begin
					cnt_ff[gi] <= 4'h0;
					tog_ff[gi] <= 1'b0;
				end else if (ce) begin
					cnt_ff[gi] <= nxt_cnt[gi];
					tog_ff[gi] <= nxt_tog[gi];
				end
			end
			assign div_out[gi] = tog_ff[gi];
		end
	endgenerate

	// ==========================================
	// Outputs
	logic [3:0] pre_cnt_unused;
	assign pre_cnt_unused = pre_ratio; // Prescale is analogue-side; ratio reported
	always_comb begin
		clks.pll_en   = pll_mode;
		clks.rc_en    = (rc_mode & core_sel_rc) | por_timer_en | fscm_en |
			wdt_en | two_speed_en;
		clks.usb_clk  = usb_en & (usb_ls ? div_out[2] : div_out[1]);
		clks.core_clk = (rc_mode & core_sel_rc) ? rc_q_ff : div_out[0];
		clock_out_pin_o  = gpio_mode ? port_a_bit6_o : div_out[3];
		clock_out_pin_oe = gpio_mode ? port_a_bit6_oe : quarter_out;
	end

	// ==========================================
	// Avalon slave, one wait state
	always_comb begin
		nxt_cfg  = cfg_ff;
		nxt_ctrl = ctrl_ff;
		nxt_ack  = 1'b0;
		nxt_rd   = rd_ff;
		if (prog_load) begin
			nxt_cfg = prog_cfg;
		end
		if ((avs_read | avs_write) & ~ack_ff) begin
			nxt_ack = 1'b1;
			if (avs_write & (avs_address == ADDR_CTRL)) begin
				nxt_ctrl = avs_writedata[3:0];
			end
			case (avs_address)
				ADDR_CFG:    nxt_rd = {20'h0, cfg_ff};
				ADDR_STATUS: nxt_rd = {24'h0, pre_cnt_unused, osc_ok, pll_ok,
					gpio_mode, rc_mode};
				ADDR_CTRL:   nxt_rd = {28'h0, ctrl_ff};
				default:     nxt_rd = 32'h0;
			endcase
		end
	end
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			cfg_ff  <= CFG_RESET;
			ctrl_ff <= CTRL_RESET;
			ack_ff  <= 1'b0;
			rd_ff   <= 32'h0;
		end else if (ce) begin
			cfg_ff  <= nxt_cfg;
			ctrl_ff <= nxt_ctrl;
			ack_ff  <= nxt_ack;
			rd_ff   <= nxt_rd;
		end
	end
	assign avs_waitrequest = (avs_read | avs_write) & ~ack_ff;
	assign avs_readdata    = rd_ff;

	// ==========================================
	// Checks
	AST_PLL_OFF: assert property (@(posedge clk_sys) disable iff (rst)
		(mode == CRYSTAL_MODE) |-> !clks.pll_en) else $error("PLL on in crystal mode");
	AST_PLL_ON: assert property (@(posedge clk_sys) disable iff (rst)
		(mode == EXTERNAL_CLOCK_PLL_GPIO_MODE) |-> clks.pll_en) else $error("PLL off");
	AST_GATE: assert property (@(posedge clk_sys) disable iff (rst)
		(ce && !pll_lock && pll_mode) |=> !div_out[1]) else $error("USB clock ungated");
	AST_GPIO: assert property (@(posedge clk_sys) disable iff (rst)
		gpio_mode |-> (clock_out_pin_oe == port_a_bit6_oe)) else $error("pin not GPIO");
	AST_QOUT: assert property (@(posedge clk_sys) disable iff (rst)
		quarter_out |-> clock_out_pin_oe) else $error("quarter output off");
	AST_RC: assert property (@(posedge clk_sys) disable iff (rst)
		wdt_en |-> clks.rc_en) else $error("RC off with watchdog");
	// Quarter divider must keep counting before crystal start-up ends in external-clock modes
	AST_EXT: assert property (@(posedge clk_sys) disable iff (rst)
		(ce && ext_mode && !osc_stable && osc_rise) |=> $changed(cnt_ff[3]))
		else $error("start-up delay in external mode");
	AST_CFG: assert property (@(posedge clk_sys) disable iff (rst)
		(ce && !prog_load) |=> $stable(cfg_ff)) else $error("config changed");
	AST_BUS: assert property (@(posedge clk_sys) disable iff (rst)
		(avs_read && !ack_ff && ce) |=> !avs_waitrequest || !avs_read) else $error("bus hang");
endmodule : osc_tree

// *** core/osc_tree_pkg.sv ***
package osc_tree_pkg;
	// ==========================================
	// Oscillator modes, four-bit field
	typedef enum logic [3:0] {
		CRYSTAL_MODE                    = 4'h0,
		CRYSTAL_PLL_MODE                = 4'h1,
		FAST_CRYSTAL_MODE               = 4'h2,
		FAST_CRYSTAL_PLL_MODE           = 4'h3,
		EXTERNAL_CLOCK_MODE             = 4'h4,
		EXTERNAL_CLOCK_GPIO_MODE        = 4'h5,
		EXTERNAL_CLOCK_PLL_MODE         = 4'h6,
		EXTERNAL_CLOCK_PLL_GPIO_MODE    = 4'h7,
		RC_CORE_FAST_CRYSTAL_USB_MODE   = 4'h8,
		RC_CORE_CRYSTAL_USB_MODE        = 4'h9,
		RC_CORE_EXTCLK_GPIO_MODE        = 4'hA,
		RC_CORE_EXTCLK_QUARTER_OUT_MODE = 4'hB
	} osc_mode_e;

	// ==========================================
	// Avalon register map (byte addresses)
	localparam logic [3:0]  ADDR_CFG      = 4'h0;
	localparam logic [3:0]  ADDR_STATUS   = 4'h4;
	localparam logic [3:0]  ADDR_CTRL     = 4'h8;
	localparam int          CFG_MODE_LSB  = 0;
	localparam int          CFG_CPU_LSB   = 4;
	localparam int          CFG_PRE_LSB   = 8;
	localparam int          CFG_USBLS_BIT = 11;
	localparam logic [11:0] CFG_RESET     = 12'h000;
	localparam logic [3:0]  CTRL_RESET    = 4'h0;

	// ==========================================
	// Frequencies in kHz; divider ratios
	localparam int          PLL_REF_KHZ  = 4000;
	localparam int          PLL_OUT_KHZ  = 96000;
	localparam int          USB_FS_KHZ   = 48000;
	localparam int          USB_LS_KHZ   = 6000;
	localparam int          MAX_IN_KHZ   = 48000;
	localparam int          CLK_SYS_KHZ  = 25000;
	localparam logic [3:0]  USB_FS_DIV   = 4'(PLL_OUT_KHZ / USB_FS_KHZ);
	localparam logic [3:0]  LS_DIV       = 4'h4;
	localparam logic [3:0]  CLKOUT_DIV   = 4'h4;
	localparam int          NUM_MODES    = 12;

	typedef struct packed {
		logic usb_clk;
		logic core_clk;
		logic pll_en;
		logic rc_en;
	} clk_out_s;
endpackage : osc_tree_pkg
